/* ild_decoder.sv */
// Purpose: fetch instruction bytes, find each length, sequence multi-step ops to the datapath
// Assumes: one fetch outstanding; datapath acks each step and updates B before the next cycle
// Notes: short, relative and long jumps and no-operation retire here without a datapath step; indexed jumps use the datapath
`timescale 1ns/100ps
module ild_decoder
    import ild_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rstn,
    output ild_fetch_s       o_fetch,
    input  ild_byte_s        i_byte,
    output ild_uop_s         o_uop,
    input  ild_ack_s         i_ack,
    input  wire logic [15:0] i_reg_b,
    input  wire logic [15:0] i_reg_k,
    output logic [15:0]      o_pc
);

    ild_state_e  state_q;
    ild_state_e  state_d;
    ild_step_e   step_q;
    ild_step_e   step_d;
    ild_step_e   step_first;
    logic [1:0]  cnt_q;
    logic [1:0]  cnt_d;
    logic [15:0] pc_q;
    logic [15:0] pc_d;
    logic [15:0] ipc_q;
    logic [15:0] ipc_d;
    logic [7:0]  op_q;
    logic [7:0]  op_d;
    logic [15:0] opr_q;
    logic [15:0] opr_d;
    ild_dec_s    dec_q;
    ild_dec_s    dec_d;
    ild_dec_s    dec;
    logic        skip_q;
    logic        skip_d;
    ild_fetch_s  fetch_q;
    ild_fetch_s  fetch_d;
    ild_uop_s    uop_q;
    ild_uop_s    uop_d;

    // Byte intake
    wire logic       byte_in = (state_q == S_WAIT) && i_byte.valid;
    wire logic       first_b = byte_in && (cnt_q == 2'h0);
    wire logic [7:0] lut_op  = (cnt_q == 2'h0) ? i_byte.data : op_q;
    wire logic       last_b  = byte_in && ((cnt_q + 2'h1) == dec.len);

    ild_len_lut u_len (
        .i_opcode (lut_op),
        .o_dec    (dec)
    );

    assign op_d  = first_b ? i_byte.data : op_q;
    assign ipc_d = first_b ? pc_q : ipc_q;
    assign dec_d = last_b ? dec : dec_q;
    // Operand starts at zero so a one-byte instruction never carries the last one's bytes
    assign opr_d = first_b ? 16'h0000 :
                   (byte_in && cnt_q == 2'h1) ? {8'h00, i_byte.data} :
                   (byte_in && cnt_q == 2'h2) ? {i_byte.data, opr_q[7:0]} : opr_q;

    // Relative targets count from the opcode address plus one
    wire ild_kind_e   kind_q = dec_q.kind;
    wire logic [15:0] sj_ofs = {{(16 - SJ_W){op_q[SJ_W-1]}}, op_q[SJ_W-1:0]};
    wire logic [15:0] rc_ofs = {{(16 - RC_HI_W - 8){op_q[RC_HI_W-1]}}, op_q[RC_HI_W-1:0], opr_q[7:0]};
    wire logic [15:0] rb_ofs = {{7{op_q[0]}}, op_q[0], opr_q[7:0]};
    wire logic [15:0] ofs    = (kind_q == K_SHORT_JUMP) ? sj_ofs :
                               (kind_q == K_REL_CALL)   ? rc_ofs :
                               (kind_q == K_REL_BRANCH) ? rb_ofs : opr_q;
    wire logic [15:0] rel_pc  = ipc_q + ofs + 16'h0001;
    wire logic [15:0] jump_pc = (kind_q == K_NOP) ? pc_q : rel_pc;

    wire logic dp_kind  = !(kind_q inside {K_NOP, K_SHORT_JUMP, K_REL_BRANCH, K_LONG_BR});
    wire logic is_table = kind_q == K_TABLE_CALL;
    wire logic acked    = uop_q.valid && i_ack.valid;

    // Post-decrement walks downward, so its loop ends below K
    wire logic cmp_skip = op_q[F_DEC] ? (i_reg_b < i_reg_k) : (i_reg_b > i_reg_k);

    // Table words are two bytes apart; direct operands land in the low page where registers live
    wire logic [15:0] tbl_addr = TABLE_BASE + {11'h000, op_q[TC_IDX_W-1:0], 1'b0};
    wire logic [15:0] dir_addr = {8'h00, opr_q[7:0]};
    wire logic [15:0] uop_addr = (step_q == ST_LOAD_TABLE) ? tbl_addr : dir_addr;

    assign step_first = (dec.kind == K_B_SKIP) ? ST_MEM_B :
                        (dec.kind inside {K_TABLE_CALL, K_REL_CALL, K_LONG_CALL}) ? ST_PUSH_PC : ST_EXEC;

    assign fetch_d = '{req: (state_q == S_FETCH), addr: pc_q};

    // Valid drops for one cycle after each ack, so a step is never taken twice
    assign uop_d = '{valid:   (state_q == S_STEP) && dp_kind && !acked,
                     step:    step_q,
                     kind:    kind_q,
                     opcode:  op_q,
                     operand: opr_q,
                     addr:    uop_addr,
                     ret_pc:  pc_q,
                     wide:    dec_q.wide,
                     imm:     dec_q.imm};

    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        cnt_d   = cnt_q;
        pc_d    = pc_q;
        skip_d  = skip_q;
        case (state_q)
            S_FETCH: begin
                state_d = S_WAIT;
            end
            S_WAIT: begin
                if (byte_in) begin
                    pc_d  = pc_q + 16'h0001;
                    cnt_d = cnt_q + 2'h1;
                    if (last_b) begin
                        cnt_d = 2'h0;
                        if (skip_q) begin
                            skip_d  = 1'b0;
                            state_d = S_FETCH;
                        end else begin
                            state_d = S_STEP;
                            step_d  = step_first;
                        end
                    end else begin
                        state_d = S_FETCH;
                    end
                end
            end
            S_STEP: begin
                if (!dp_kind) begin
                    pc_d    = jump_pc;
                    state_d = S_FETCH;
                end else if (acked) begin
                    case (step_q)
                        ST_MEM_B: begin
                            step_d = ST_B_ADJ;
                        end
                        ST_B_ADJ: begin
                            state_d = S_CHECK;
                        end
                        ST_PUSH_PC: begin
                            step_d = ST_SP_ADD2;
                        end
                        ST_SP_ADD2: begin
                            if (is_table) begin
                                step_d = ST_LOAD_TABLE;
                            end else begin
                                pc_d    = rel_pc;
                                state_d = S_FETCH;
                            end
                        end
                        ST_LOAD_TABLE: begin
                            pc_d    = i_ack.pc;
                            state_d = S_FETCH;
                        end
                        default: begin
                            if (i_ack.load_pc) begin
                                pc_d = i_ack.pc;
                            end
                            skip_d  = i_ack.skip || (kind_q == K_RET_SKIP);
                            state_d = S_FETCH;
                        end
                    endcase
                end
            end
            S_CHECK: begin
                skip_d  = cmp_skip;
                state_d = S_FETCH;
            end
            default: begin
                state_d = S_FETCH;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= S_FETCH;
            step_q  <= ST_EXEC;
            cnt_q   <= 2'h0;
            pc_q    <= RESET_PC;
            ipc_q   <= RESET_PC;
            op_q    <= 8'h00;
            opr_q   <= 16'h0000;
            dec_q   <= '0;
            skip_q  <= 1'b0;
            fetch_q <= '0;
            uop_q   <= '0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
            cnt_q   <= cnt_d;
            pc_q    <= pc_d;
            ipc_q   <= ipc_d;
            op_q    <= op_d;
            opr_q   <= opr_d;
            dec_q   <= dec_d;
            skip_q  <= skip_d;
            fetch_q <= fetch_d;
            uop_q   <= uop_d;
        end
    end

    assign o_fetch = fetch_q;
    assign o_uop   = uop_q;
    assign o_pc    = ipc_q;

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    wire logic        in_step = state_q == S_STEP;
    wire logic [15:0] span    = pc_q - ipc_q;

    xs_skip_a: assert property (
        state_q == S_CHECK && !op_q[F_DEC] && (i_reg_b > i_reg_k) |=> skip_q)
        else $error("exchange-with-skip did not skip past K");

    xs_steps_a: assert property (
        uop_q.valid && uop_q.step == ST_MEM_B && i_ack.valid
        |-> ##2 (uop_q.valid && uop_q.step == ST_B_ADJ))
        else $error("B step did not follow memory step");

    sj_range_a: assert property (
        in_step && kind_q == K_SHORT_JUMP
        |-> span == 16'h0001 ##1 ($signed(pc_q - ipc_q) <= 32 && $signed(pc_q - ipc_q) >= -31))
        else $error("short jump length or reach wrong");

    tcall_len_a: assert property (
        in_step && is_table |-> span == 16'h0001 && op_q[7:4] == OP_TC)
        else $error("table call not one byte");

    rcall_len_a: assert property (
        in_step && kind_q == K_REL_CALL |-> span == 16'h0002)
        else $error("relative call not two bytes");

    bit_len_a: assert property (
        in_step && kind_q == K_BIT |-> span == (op_q[F_DIR] ? 16'h0002 : 16'h0001))
        else $error("bit op length wrong");

    mmio_addr_a: assert property (
        uop_q.valid && uop_q.kind == K_BIT && uop_q.opcode[F_DIR]
        |-> uop_q.addr == {8'h00, uop_q.operand[7:0]})
        else $error("direct bit address outside register page");

    dec_width_a: assert property (
        in_step && kind_q == K_ARITH && !op_q[F_MULDIV]
        |-> dec_q.wide == op_q[F_WIDE] && span == ((op_q[F_WIDE] && op_q[F_IMM]) ? 16'h0003 : 16'h0002))
        else $error("decimal op width or length wrong");

    muldiv_word_a: assert property (
        uop_q.valid && uop_q.kind == K_ARITH && uop_q.opcode[F_MULDIV]
        |-> uop_q.wide && uop_q.imm == uop_q.opcode[F_IMM])
        else $error("multiply or divide not on words");

    ptr_len_a: assert property (
        in_step && kind_q inside {K_B_SKIP, K_X_PTR} |-> span == 16'h0001)
        else $error("pointer op not one byte");

    acc_len_a: assert property (
        in_step && kind_q == K_ACC |-> span == 16'h0001)
        else $error("accumulator op not one byte");

    ctrl_len_a: assert property (
        in_step && kind_q inside {K_LONG_CALL, K_LONG_BR, K_REL_BRANCH, K_NOP, K_RETURN, K_IND_TABLE}
        |-> span == ((kind_q inside {K_LONG_CALL, K_LONG_BR}) ? 16'h0003 :
                     (kind_q == K_REL_BRANCH) ? 16'h0002 : 16'h0001))
        else $error("control transfer length wrong");

    tcall_seq_a: assert property (
        uop_q.valid && uop_q.step == ST_SP_ADD2 && is_table && i_ack.valid
        |-> ##2 (uop_q.valid && uop_q.step == ST_LOAD_TABLE && uop_q.addr == tbl_addr))
        else $error("table load did not follow stack step");

    skip_drop_a: assert property (
        skip_q && last_b |=> (state_q == S_FETCH && !skip_q && !uop_q.valid) ##1 !uop_q.valid)
        else $error("skipped instruction reached the datapath");

    xs_skip_c:   cover property (state_q == S_CHECK && cmp_skip);
    tcall_c:     cover property (uop_q.valid && uop_q.step == ST_LOAD_TABLE && i_ack.valid);
    skip_drop_c: cover property (skip_q && last_b && dec.len == LEN3);
    lcall_c:     cover property (in_step && kind_q == K_LONG_CALL && acked);

endmodule : ild_decoder

/* ild_pkg.sv */
// Purpose: shared constants, opcode map and carrier types of the instruction length decoder
// Assumes: one-byte opcodes, little-endian operand bytes, 16-bit program addresses
// Notes: the opcode map is local to this core; datapath and assembler must share it
package ild_pkg;

    localparam logic [15:0] RESET_PC   = 16'h0000;
    localparam logic [15:0] TABLE_BASE = 16'hffe0;

    // Opcode group patterns, compared against the top bits of the opcode, except ACC_LAST (bits 3:0) and BIT_BAD (bits 4:3)
    localparam logic [1:0] OP_SJ    = 2'h0;
    localparam logic [3:0] OP_TC    = 4'h4;
    localparam logic [4:0] OP_RC    = 5'h0a;
    localparam logic [6:0] OP_RB    = 7'h2c;
    localparam logic [7:0] OP_LCALL = 8'h5a;
    localparam logic [7:0] OP_LBR   = 8'h5b;
    localparam logic [7:0] OP_JIDX  = 8'h5c;
    localparam logic [7:0] OP_JIDXW = 8'h5d;
    localparam logic [7:0] OP_NOP   = 8'h5e;
    localparam logic [7:0] OP_RET   = 8'h5f;
    localparam logic [7:0] OP_RETSK = 8'h60;
    localparam logic [7:0] OP_INTERRUPT_RETURN  = 8'h61;
    localparam logic [5:0] OP_BSK   = 6'h19;
    localparam logic [5:0] OP_XP    = 6'h1a;
    localparam logic [3:0] OP_ACC   = 4'h7;
    localparam logic [3:0] ACC_LAST = 4'hc;
    localparam logic [1:0] OP_BIT   = 2'h2;
    localparam logic [1:0] BIT_BAD  = 2'h3;
    localparam logic [3:0] OP_AR    = 4'hc;

    // Field positions and widths inside the opcode
    localparam int unsigned F_DEC    = 0;
    localparam int unsigned F_XCHG   = 1;
    localparam int unsigned F_IMM    = 0;
    localparam int unsigned F_WIDE   = 1;
    localparam int unsigned F_MULDIV = 3;
    localparam int unsigned F_DIR    = 5;
    localparam int unsigned SJ_W     = 6;
    localparam int unsigned RC_HI_W  = 3;
    localparam int unsigned TC_IDX_W = 4;

    localparam logic [1:0] LEN1 = 2'h1;
    localparam logic [1:0] LEN2 = 2'h2;
    localparam logic [1:0] LEN3 = 2'h3;

    typedef enum logic [4:0] {
        K_NOP        = 5'h00,
        K_SHORT_JUMP = 5'h01,
        K_TABLE_CALL = 5'h02,
        K_REL_CALL   = 5'h03,
        K_REL_BRANCH = 5'h04,
        K_LONG_CALL  = 5'h05,
        K_LONG_BR    = 5'h06,
        K_IND_TABLE  = 5'h07,
        K_IND_WTABLE = 5'h08,
        K_RETURN     = 5'h09,
        K_RET_SKIP   = 5'h0a,
        K_INT_RETURN = 5'h0b,
        K_B_SKIP     = 5'h0c,
        K_X_PTR      = 5'h0d,
        K_ACC        = 5'h0e,
        K_BIT        = 5'h0f,
        K_ARITH      = 5'h10,
        K_ILLEGAL    = 5'h11
    } ild_kind_e;

    typedef enum logic [2:0] {
        ST_EXEC       = 3'h0,
        ST_MEM_B      = 3'h1,
        ST_B_ADJ      = 3'h2,
        ST_PUSH_PC    = 3'h3,
        ST_SP_ADD2    = 3'h4,
        ST_LOAD_TABLE = 3'h5
    } ild_step_e;

    typedef enum logic [1:0] {
        S_FETCH = 2'h0,
        S_WAIT  = 2'h1,
        S_STEP  = 2'h2,
        S_CHECK = 2'h3
    } ild_state_e;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
    } ild_fetch_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ild_byte_s;

    typedef struct packed {
        logic [1:0] len;
        ild_kind_e  kind;
        logic       wide;
        logic       imm;
    } ild_dec_s;

    typedef struct packed {
        logic        valid;
        ild_step_e   step;
        ild_kind_e   kind;
        logic [7:0]  opcode;
        logic [15:0] operand;
        logic [15:0] addr;
        logic [15:0] ret_pc;
        logic        wide;
        logic        imm;
    } ild_uop_s;

    typedef struct packed {
        logic        valid;
        logic        skip;
        logic        load_pc;
        logic [15:0] pc;
    } ild_ack_s;

endpackage : ild_pkg

/* ild_len_lut.sv */
// Purpose: classify one opcode byte and give its total byte length
// Assumes: purely combinational, opcode stable while it is read
// Notes: unknown opcodes are one byte long so a stray byte never stalls fetch
`timescale 1ns/100ps
module ild_len_lut
    import ild_pkg::*;
(
    input  wire logic [7:0] i_opcode,
    output ild_dec_s        o_dec
);

    wire logic [7:0] op = i_opcode;

    wire logic g_sj  = op[7:6] == OP_SJ;
    wire logic g_tc  = op[7:4] == OP_TC;
    wire logic g_rc  = op[7:3] == OP_RC;
    wire logic g_rb  = op[7:1] == OP_RB;
    wire logic g_bsk = op[7:2] == OP_BSK;
    wire logic g_xp  = op[7:2] == OP_XP;
    wire logic g_acc = (op[7:4] == OP_ACC) && (op[3:0] <= ACC_LAST);
    wire logic g_bit = (op[7:6] == OP_BIT) && (op[4:3] != BIT_BAD);
    wire logic g_ar  = op[7:4] == OP_AR;
    wire logic g_lng = (op == OP_LCALL) || (op == OP_LBR);
    // Multiply and divide always run on words
    wire logic ar_wide = op[F_WIDE] || op[F_MULDIV];

    ild_kind_e  kind;
    logic [1:0] len;

    assign kind = g_sj             ? K_SHORT_JUMP :
                  g_tc             ? K_TABLE_CALL :
                  g_rc             ? K_REL_CALL   :
                  g_rb             ? K_REL_BRANCH :
                  (op == OP_LCALL) ? K_LONG_CALL  :
                  (op == OP_LBR)   ? K_LONG_BR    :
                  (op == OP_JIDX)  ? K_IND_TABLE  :
                  (op == OP_JIDXW) ? K_IND_WTABLE :
                  (op == OP_NOP)   ? K_NOP        :
                  (op == OP_RET)   ? K_RETURN     :
                  (op == OP_RETSK) ? K_RET_SKIP   :
                  (op == OP_INTERRUPT_RETURN)  ? K_INT_RETURN :
                  g_bsk            ? K_B_SKIP     :
                  g_xp             ? K_X_PTR      :
                  g_acc            ? K_ACC        :
                  g_bit            ? K_BIT        :
                  g_ar             ? K_ARITH      : K_ILLEGAL;

    assign len = (g_rc || g_rb)             ? LEN2 :
                 g_lng                      ? LEN3 :
                 (g_bit && op[F_DIR])       ? LEN2 :
                 (g_ar && op[F_IMM] && ar_wide) ? LEN3 :
                 g_ar                       ? LEN2 : LEN1;

    assign o_dec = '{len: len, kind: kind, wide: g_ar && ar_wide, imm: g_ar && op[F_IMM]};

endmodule : ild_len_lut

/* ild_prog_mem.sv */
// Purpose: program memory model that answers the decoder's instruction fetches
// Assumes: one fetch outstanding; latency in cycles set by i_delay, 0 answers in the request cycle
// Notes: the data line shows the inverse of the last byte whenever no byte is offered
`timescale 1ns/100ps
module ild_prog_mem
    import ild_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    input  ild_fetch_s      i_fetch,
    input  wire logic [3:0] i_delay,
    output ild_byte_s       o_byte
);
    logic [7:0]  mem [0:65535];
    logic [15:0] addr_q;
    logic [3:0]  cnt_q;
    logic        busy_q;
    logic [7:0]  last_q;
    wire         now_req  = i_fetch.req && (i_delay == 4'h0);
    wire         now_late = busy_q && (cnt_q == 4'h0);
    wire  [15:0] rd_addr  = now_req ? i_fetch.addr : addr_q;
    wire         byte_ok  = now_req || now_late;

    // Never show a stale byte, so a decoder that samples early cannot pass by luck
    assign o_byte = '{valid: byte_ok, data: byte_ok ? mem[rd_addr] : ~last_q};

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_q <= 1'b0;
            cnt_q  <= 4'h0;
            addr_q <= 16'h0000;
            last_q <= 8'h00;
        end else begin
            if (o_byte.valid) begin
                last_q <= o_byte.data;
            end
            if (i_fetch.req && (i_delay != 4'h0)) begin
                busy_q <= 1'b1;
                addr_q <= i_fetch.addr;
                cnt_q  <= i_delay - 4'h1;
            end else if (now_late) begin
                busy_q <= 1'b0;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule : ild_prog_mem

/* testbench.sv */
// Purpose: self-checking bench for the instruction length decoder
// Assumes: bench plays the datapath, acking each step one cycle after it appears
// Notes: each scenario restarts from reset, since only reset or a jump places the pc
`timescale 1ns/100ps
module testbench
    import ild_pkg::*;
;
    logic        i_sys_clk;
    logic        i_rstn;
    ild_fetch_s  o_fetch;
    ild_byte_s   i_byte;
    ild_uop_s    o_uop;
    ild_ack_s    i_ack;
    logic [15:0] i_reg_b;
    logic [15:0] i_reg_k;
    logic [15:0] o_pc;
    logic [3:0]  mem_dly;
    int          fail_count;
    int          n_checks;
    logic [15:0] fq [$];
    logic [15:0] pq [$];
    ild_uop_s    uq [$];

    ild_decoder u_ild_decoder (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .o_fetch(o_fetch), .i_byte(i_byte),
        .o_uop(o_uop), .i_ack(i_ack), .i_reg_b(i_reg_b), .i_reg_k(i_reg_k), .o_pc(o_pc));
    ild_prog_mem u_ild_prog_mem (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_fetch(o_fetch),
        .i_delay(mem_dly), .o_byte(i_byte));

    initial begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    // Datapath stand-in: log fetches and steps, ack each step, step B as asked
    always @(posedge i_sys_clk) begin
        i_ack.valid <= o_uop.valid && !i_ack.valid;
        if (o_fetch.req) begin
            fq.push_back(o_fetch.addr);
        end
        if (o_uop.valid && i_ack.valid) begin
            uq.push_back(o_uop);
            pq.push_back(o_pc);
            if (o_uop.step == ST_B_ADJ) begin
                i_reg_b <= o_uop.opcode[0] ? i_reg_b - 16'h1 : i_reg_b + 16'h1;
            end
        end
    end

    task automatic test_done();
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_ild_prog_mem.mem[a] = d;
    endtask : wr

    task automatic restart(input logic [3:0] dly, input logic [15:0] b, input logic [15:0] k);
        @(posedge i_sys_clk);
        i_rstn  <= 1'b0;
        mem_dly <= dly;
        i_reg_b <= b;
        i_reg_k <= k;
        for (int a = 0; a < 65536; a++) u_ild_prog_mem.mem[a] = OP_NOP;
    endtask : restart

    task automatic start();
        repeat (5) @(posedge i_sys_clk);
        fq.delete();
        uq.delete();
        pq.delete();
        i_rstn <= 1'b1;
    endtask : start

    task automatic wait_fetch(input int n);
        int t;
        t = 0;
        while (fq.size() < n && t < 2000) begin
            @(posedge i_sys_clk);
            t++;
        end
        if (t == 2000) fail_count++;
    endtask : wait_fetch

    task automatic run_lengths();
        logic [7:0]  ops [14] = '{8'h5e, 8'h70, 8'h7c, 8'h68, 8'h6b, 8'h80, 8'h88, 8'ha0, 8'hb0, 8'hc0,
                                  8'hc3, 8'hc6, 8'hc8, 8'hcd};
        int          lens [14] = '{1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 3, 2, 2, 3};
        ild_kind_e   kinds [14] = '{K_NOP, K_ACC, K_ACC, K_X_PTR, K_X_PTR, K_BIT, K_BIT, K_BIT, K_BIT,
                                    K_ARITH, K_ARITH, K_ARITH, K_ARITH, K_ARITH};
        logic [1:0]  wi [14] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 2'h0, 2'h3, 2'h2, 2'h2, 2'h3};
        logic [15:0] ps [14];
        logic [15:0] eo [14];
        logic [15:0] ef [$];
        logic [15:0] pc;
        logic [7:0]  b1;
        logic [7:0]  b2;
        restart(4'h2, 16'h0, 16'h0);
        pc = 16'h0;
        for (int i = 0; i < 14; i++) begin
            b1 = 8'(pc + 16'h41);
            b2 = 8'(pc + 16'h42);
            wr(pc, ops[i]);
            wr(pc + 16'h1, b1);
            wr(pc + 16'h2, b2);
            ps[i] = pc;
            eo[i] = {(lens[i] > 2) ? b2 : 8'h00, (lens[i] > 1) ? b1 : 8'h00};
            for (int k = 0; k < lens[i]; k++) ef.push_back(pc + 16'(k));
            pc = pc + 16'(lens[i]);
        end
        ef.push_back(pc);
        start();
        wait_fetch(ef.size());
        foreach (ef[j]) chk(fq[j], ef[j]);
        chk(uq.size(), 13);
        for (int i = 1; i < 14; i++) begin
            chk({uq[i-1].step, uq[i-1].kind, uq[i-1].opcode}, {ST_EXEC, kinds[i], ops[i]});
            chk({uq[i-1].operand, uq[i-1].ret_pc}, {eo[i], ps[i] + 16'(lens[i])});
            chk(pq[i-1], ps[i]);
            if (kinds[i] == K_ARITH) chk({uq[i-1].wide, uq[i-1].imm}, wi[i]);
            if (lens[i] == 2) chk(uq[i-1].addr, {8'h00, eo[i][7:0]});
        end
    endtask : run_lengths

    task automatic run_transfers();
        logic [15:0] ef [11] = '{16'h0, 16'h20, 16'h1, 16'h2, 16'h401, 16'h200, 16'h201, 16'h202,
                                 16'h211, 16'h212, 16'h217};
        restart(4'h0, 16'h0, 16'h0);
        wr(16'h0, 8'h1f);
        wr(16'h20, 8'h20);
        wr(16'h1, 8'h53);
        wr(16'h2, 8'hff);
        wr(16'h401, 8'h4f);
        wr(16'h200, 8'h5b);
        wr(16'h201, 8'h10);
        wr(16'h202, 8'h00);
        wr(16'h211, 8'h58);
        wr(16'h212, 8'h05);
        start();
        wait_fetch(11);
        for (int j = 0; j < 11; j++) chk(fq[j], ef[j]);
        chk({uq[0].step, uq[0].ret_pc}, {ST_PUSH_PC, 16'h3});
        chk(uq[1].step, ST_SP_ADD2);
        chk({uq[2].step, uq[2].ret_pc}, {ST_PUSH_PC, 16'h402});
        chk(uq[3].step, ST_SP_ADD2);
        chk({uq[4].step, uq[4].addr}, {ST_LOAD_TABLE, TABLE_BASE + 16'h1e});
        chk(uq.size(), 5);
    endtask : run_transfers

    task automatic run_skips();
        logic [7:0]  ops [5] = '{8'h66, 8'h66, 8'h67, 8'h67, 8'h64};
        logic [15:0] bs [5] = '{16'h5, 16'h4, 16'h5, 16'h6, 16'h6};
        logic [15:0] ks [5] = '{16'h5, 16'h5, 16'h5, 16'h5, 16'h6};
        logic        sk [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 5; i++) begin
            restart(4'(i), bs[i], ks[i]);
            wr(16'h0, ops[i]);
            wr(16'h1, 8'hc3);
            wr(16'h2, 8'h41);
            wr(16'h3, 8'h42);
            wr(16'h4, 8'h70);
            start();
            wait_fetch(6);
            for (int j = 0; j < 6; j++) chk(fq[j], 16'(j));
            chk({uq[0].step, uq[0].opcode, uq[1].step}, {ST_MEM_B, ops[i], ST_B_ADJ});
            chk(uq[2].opcode, sk[i] ? 8'h70 : 8'hc3);
            chk(uq.size(), sk[i] ? 3 : 4);
        end
    endtask : run_skips

    // Return-and-skip lands at the ack pc and drops the three-byte instruction there
    task automatic run_returns();
        logic [15:0] ef [6] = '{16'h0, 16'h200, 16'h201, 16'h202, 16'h203, 16'h200};
        restart(4'h1, 16'h0, 16'h0);
        i_ack.load_pc <= 1'b1;
        wr(16'h0, OP_RETSK);
        wr(16'h200, 8'hc3);
        wr(16'h203, 8'h70);
        start();
        wait_fetch(6);
        foreach (ef[j]) chk(fq[j], ef[j]);
        chk({uq[0].opcode, uq[1].opcode}, {OP_RETSK, 8'h70});
        chk(uq.size(), 2);
        i_ack.load_pc <= 1'b0;
    endtask : run_returns

    initial begin
        fail_count = 0;
        n_checks   = 0;
        i_rstn     = 1'b0;
        i_reg_b    = 16'h0;
        i_reg_k    = 16'h0;
        mem_dly    = 4'h0;
        i_ack      = '{valid: 1'b0, skip: 1'b0, load_pc: 1'b0, pc: 16'h0200};
        run_lengths();
        run_transfers();
        run_skips();
        run_returns();
        test_done();
    end

    // Every scenario ends within a few hundred cycles; this only catches a hang
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        test_done();
    end
endmodule : testbench
